// [inc/adp_pkg.sv]
// package for the converter digital pin interface
// assumes one system clock domain; pins are resynchronised inside the top
package adp_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int unsigned SYS_CLK_HZ    = 10_000_000;
   localparam int unsigned MCLK_OUT_HZ   = 1_000_000;
   localparam int unsigned MCLK_HALF_CYC = SYS_CLK_HZ / (2 * MCLK_OUT_HZ);
   localparam logic [7:0]  MCLK_HALF_LAST = 8'(MCLK_HALF_CYC - 1);

   // ----------------------------------------
   // serial frame layout
   // ----------------------------------------
   localparam int unsigned CMD_BITS    = 8;
   localparam int unsigned FRAME_BITS  = 16;
   localparam logic [4:0]  CNT_CMD_END = 5'h08;
   localparam logic [4:0]  CNT_FRM_END = 5'h10;
   localparam int unsigned CMD_RD_POS  = 6;     // 1 = read access
   localparam int unsigned RS_MSB      = 5;     // register select field [5:0]
   localparam int unsigned SPI_NREG    = 16;    // implemented serial registers
   localparam logic [7:0]  SPI_REG_RST = 8'h00;

   // ----------------------------------------
   // wishbone register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADR_CTRL    = 8'h00;
   localparam logic [7:0] ADR_STATUS  = 8'h04;
   localparam logic [7:0] ADR_MASK    = 8'h08;
   localparam logic [7:0] ADR_SPISTAT = 8'h0C;

   // control register fields
   localparam int unsigned CTL_FIFO_EN   = 0;
   localparam int unsigned CTL_INT_FIFO  = 1;
   localparam int unsigned CTL_CLK_OUT   = 2;
   localparam int unsigned CTL_CLK_EXT   = 3;
   localparam int unsigned CTL_CLK_IRQ   = 4;
   localparam int unsigned CTL_SYNC_CLR  = 5;
   localparam int unsigned CTL_W         = 6;
   localparam logic [5:0]  CTL_RST       = 6'h00;

   // status / mask fields
   localparam int unsigned EV_SPI_WR = 0;
   localparam int unsigned EV_SPI_RD = 1;
   localparam int unsigned EV_SYNC   = 2;
   localparam int unsigned EV_DRDY   = 3;
   localparam int unsigned EV_W      = 4;
   localparam logic [3:0]  EV_RST    = 4'h0;
endpackage

// [design/adp_pin_if.sv]
// digital pin interface of a sigma-delta converter: serial port slave,
// interrupt pin, sync input and two-way master clock pin, with a wishbone
// control port and a level interrupt toward the local processor.
// assumes pins are asynchronous to sys_clk and sclk is much slower than it.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
module adp_pin_if
   import adp_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   // wishbone classic slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   output logic             irq,
   // serial port pins
   input  wire logic        sclk,
   input  wire logic        csN,
   input  wire logic        din,
   output logic             dout,
   output logic             doutOeN,
   // interrupt, sync, clock pins
   output logic             intPin,
   input  wire logic        syncN,
   input  wire logic        clkPinIn,
   output logic             clkPinOut,
   output logic             clkPinOeN,
   // converter core side
   input  wire logic        dataReady,
   input  wire logic        fifoIrq,
   input  wire logic        fifoReady,
   output logic             syncAlign,
   output logic             fifoClear,
   output logic             seqRestart,
   output logic             mclkTick
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] sclkS_q, csS_q, dinS_q, syncS_q, clkInS_q;
   logic       sclkD_q, syncD_q, clkInD_q;

   // two stages per pin; only stage two is read by logic
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sclkS_q  <= 2'h3;
         csS_q    <= 2'h3;
         dinS_q   <= 2'h0;
         syncS_q  <= 2'h3;
         clkInS_q <= 2'h0;
         sclkD_q  <= 1'b1;
         syncD_q  <= 1'b1;
         clkInD_q <= 1'b0;
      end else begin
         sclkS_q  <= {sclkS_q[0], sclk};
         csS_q    <= {csS_q[0], csN};
         dinS_q   <= {dinS_q[0], din};
         syncS_q  <= {syncS_q[0], syncN};
         clkInS_q <= {clkInS_q[0], clkPinIn};
         sclkD_q  <= sclkS_q[1];
         syncD_q  <= syncS_q[1];
         clkInD_q <= clkInS_q[1];
      end
   end

   logic sclkRise, csLow, syncFall, clkInRise;
   assign sclkRise  = sclkS_q[1] & ~sclkD_q;
   assign csLow     = ~csS_q[1];
   assign syncFall  = ~syncS_q[1] & syncD_q;
   assign clkInRise = clkInS_q[1] & ~clkInD_q;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   logic [CTL_W-1:0] ctrl_q;
   logic [EV_W-1:0]  status_q, mask_q;
   logic             wbReq;
   assign wbReq = cyc_i & stb_i & ~ack_o;

   logic fifoEn, intFifo, clkOut, clkExt, clkIrq, syncClr;
   assign fifoEn  = ctrl_q[CTL_FIFO_EN];
   assign intFifo = ctrl_q[CTL_INT_FIFO];
   assign clkOut  = ctrl_q[CTL_CLK_OUT];
   assign clkExt  = ctrl_q[CTL_CLK_EXT];
   assign clkIrq  = ctrl_q[CTL_CLK_IRQ];
   assign syncClr = ctrl_q[CTL_SYNC_CLR];

   // software writes take effect on the edge that raises ack
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= CTL_RST;
         mask_q <= EV_RST;
      end else if (wbReq && we_i && sel_i[0]) begin
         if (adr_i == ADR_CTRL) ctrl_q <= dat_i[CTL_W-1:0];
         if (adr_i == ADR_MASK) mask_q <= dat_i[EV_W-1:0];
      end
   end

   // ----------------------------------------
   // serial port engine
   // ----------------------------------------
   logic [4:0]         bitCnt_q;
   logic [7:0]         cmd_q, rxSh_q, txSh_q;
   logic               rdPhase_q;
   logic [7:0]         spiReg_q [SPI_NREG];
   logic               evWr, evRd;
   logic [7:0]         rxNext;
   logic [RS_MSB:0]    rsField;
   logic [7:0]         rdVal;

   assign rxNext  = {rxSh_q[6:0], dinS_q[1]};
   assign rsField = rxNext[RS_MSB:0];
   assign rdVal   = (rsField < 6'(SPI_NREG)) ? spiReg_q[rsField[3:0]] : 8'h00;
   assign evWr    = csLow & sclkRise & (bitCnt_q == CNT_FRM_END - 5'h01) & ~cmd_q[CMD_RD_POS];
   assign evRd    = csLow & sclkRise & (bitCnt_q == CNT_CMD_END - 5'h01) & rxNext[CMD_RD_POS];

   // bit counter and input shifter; select high ends the frame, tied low
   // the count alone frames, so a lost edge misaligns until reset
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bitCnt_q <= 5'h00;
         rxSh_q   <= 8'h00;
         cmd_q    <= 8'h00;
      end else if (!csLow) begin
         bitCnt_q <= 5'h00;
      end else if (sclkRise) begin
         rxSh_q <= rxNext;
         if (bitCnt_q == CNT_CMD_END - 5'h01) cmd_q <= rxNext;
         bitCnt_q <= (bitCnt_q == CNT_FRM_END - 5'h01) ? 5'h00 : bitCnt_q + 5'h01;
      end
   end

   // serial register bank, written at the last data bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < SPI_NREG; i++) spiReg_q[i] <= SPI_REG_RST;
      end else if (evWr && cmd_q[RS_MSB:0] < 6'(SPI_NREG)) begin
         spiReg_q[cmd_q[3:0]] <= rxNext;
      end
   end

   // output shifter: loaded when a read command completes, moved after each
   // later rising sclk, so every bit stands for a whole sclk period
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         txSh_q    <= 8'h00;
         rdPhase_q <= 1'b0;
      end else if (!csLow) begin
         rdPhase_q <= 1'b0;
      end else if (evRd) begin
         txSh_q    <= rdVal;
         rdPhase_q <= 1'b1;
      end else if (sclkRise && rdPhase_q) begin
         // the sync delay eats most of a half period, so moving on
         // the falling edge would change dout as the host samples it
         txSh_q <= {txSh_q[6:0], 1'b0};
         if (bitCnt_q == CNT_FRM_END - 5'h01) rdPhase_q <= 1'b0;
      end
   end

   // serial output pin; outside a read, with the fifo on, it shows fifo ready (low = ready), else it idles high
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         dout    <= 1'b1;
         doutOeN <= 1'b1;
      end else begin
         doutOeN <= ~csLow;
         if (rdPhase_q) dout <= txSh_q[7];
         else if (fifoEn) dout <= ~fifoReady;
         else dout <= 1'b1;
      end
   end

   // ----------------------------------------
   // sync input
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         syncAlign  <= 1'b0;
         fifoClear  <= 1'b0;
         seqRestart <= 1'b0;
      end else begin
         syncAlign  <= syncFall;
         fifoClear  <= syncFall & syncClr;
         seqRestart <= syncFall & syncClr;
      end
   end

   // ----------------------------------------
   // interrupt pin and master clock pin
   // ----------------------------------------
   logic       irqSrc;
   logic [7:0] div_q;
   logic       mclkInt_q, divTick;

   // with the fifo off the selection bit is ignored, so data ready always wins
   assign irqSrc  = (fifoEn && intFifo) ? fifoIrq : dataReady;
   assign divTick = (div_q == MCLK_HALF_LAST);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) intPin <= 1'b0;
      else intPin <= irqSrc;
   end

   // internal clock divider, stopped while an external clock is used
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         div_q     <= 8'h00;
         mclkInt_q <= 1'b0;
      end else if (clkExt) begin
         div_q     <= 8'h00;
         mclkInt_q <= 1'b0;
      end else begin
         div_q <= divTick ? 8'h00 : div_q + 8'h01;
         if (divTick) mclkInt_q <= ~mclkInt_q;
      end
   end

   // pin use: interrupt beats clock out and external clock; external clock releases the pin only with interrupt off
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         clkPinOut <= 1'b0;
         clkPinOeN <= 1'b1;
         mclkTick  <= 1'b0;
      end else begin
         if (clkIrq) begin
            clkPinOut <= irqSrc;
            clkPinOeN <= 1'b0;
         end else if (clkOut && !clkExt) begin
            clkPinOut <= mclkInt_q;
            clkPinOeN <= 1'b0;
         end else begin
            clkPinOut <= 1'b0;
            clkPinOeN <= 1'b1;
         end
         mclkTick <= clkExt ? clkInRise : (divTick & ~mclkInt_q);
      end
   end

   // ----------------------------------------
   // events, wishbone answer, interrupt
   // ----------------------------------------
   logic       drdyD_q;
   logic [EV_W-1:0] evSet;
   logic       stRead;
   assign evSet  = {dataReady & ~drdyD_q, syncFall, evRd, evWr};
   assign stRead = wbReq & ~we_i & (adr_i == ADR_STATUS);

   // sticky flags cleared by a status read; a new event in that cycle stays
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         status_q <= EV_RST;
         drdyD_q  <= 1'b0;
      end else begin
         drdyD_q  <= dataReady;
         status_q <= (stRead ? EV_RST : status_q) | evSet;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) irq <= 1'b0;
      else irq <= |(status_q & mask_q);
   end

   // one wait state; unmapped addresses are acked and read as zero
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= wbReq;
         if (wbReq && !we_i) begin
            unique case (adr_i)
               ADR_CTRL:    dat_o <= {26'h0000000, ctrl_q};
               ADR_STATUS:  dat_o <= {28'h0000000, status_q};
               ADR_MASK:    dat_o <= {28'h0000000, mask_q};
               ADR_SPISTAT: dat_o <= {17'h00000, rdPhase_q, csLow, bitCnt_q, cmd_q[7:0]};
               default:     dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule

// [sim/adp_pin_if_properties.sv]
// checker: bus answer, select, sync and interrupt pin timing
// assumes bind onto adp_pin_if, one sys_clk domain
`timescale 1ns/1ns
module adp_pin_if_properties (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic csN,
   input wire logic doutOeN,
   input wire logic syncN,
   input wire logic syncAlign,
   input wire logic fifoClear,
   input wire logic seqRestart,
   input wire logic dataReady,
   input wire logic fifoIrq,
   input wire logic intPin
);
   // pins pass two sync flops and a register, hence the short windows
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
   a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
   a_oe_select: assert property ($fell(csN) |-> ##[2:5] !doutOeN) else $error("dout idle");
   a_oe_release: assert property ($rose(csN) |-> ##[2:5] doutOeN) else $error("dout held");
   a_sync_align: assert property ($fell(syncN) |-> ##[2:6] syncAlign) else $error("no align");
   a_align_pulse: assert property (syncAlign |=> !syncAlign) else $error("align held");
   a_clear_sync: assert property (fifoClear |-> syncAlign) else $error("stray clear");
   a_clear_restart: assert property (fifoClear |-> seqRestart) else $error("no restart");
   a_int_ready: assert property (dataReady && fifoIrq |=> intPin) else $error("int low");
endmodule

// attach to every pin interface instance
bind adp_pin_if adp_pin_if_properties u_props (.sys_clk(sys_clk), .nrst(nrst), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .csN(csN), .doutOeN(doutOeN), .syncN(syncN), .syncAlign(syncAlign), .fifoClear(fifoClear),
   .seqRestart(seqRestart), .dataReady(dataReady), .fifoIrq(fifoIrq), .intPin(intPin));

// [sim/adp_spi_host.sv]
// host model: serial master on the converter pins
// assumes 100 ns sys_clk; sclk half period is four of them
`timescale 1ns/1ns
module adp_spi_host (
   input  wire logic sys_clk,
   input  wire logic dout,
   output logic      sclk = 1'b1,
   output logic      csN = 1'b1,
   output logic      din = 1'b1
);
   // 16-bit frame, msb first; sclk parked high outside frames
   task automatic xfer(input logic [15:0] f, input logic gap, input logic keep, output logic [7:0] rd);
      @(posedge sys_clk);
      csN <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         repeat (4) @(posedge sys_clk);
         sclk <= 1'b0;
         din <= f[i]; // command byte then data byte
         repeat (4) @(posedge sys_clk);
         if (i < 8) rd[i] = dout; // read bit at rising sclk
         sclk <= 1'b1;
         if (gap && i == 8) repeat (12) @(posedge sys_clk); // gated clock pause
      end
      repeat (4) @(posedge sys_clk);
      if (!keep) csN <= 1'b1; // three-wire keeps select low
      din <= ~f[0]; // no stale bit on a released line
      repeat (8) @(posedge sys_clk);
   endtask
endmodule

// [sim/adp_pin_if_tb.sv]
// testbench: register bus, serial frames, interrupts, sync and clock pin
// assumes the bound checker and the host model on the serial pins
`timescale 1ns/1ns
module adp_pin_if_tb;
   import adp_pkg::*;
   logic        sys_clk, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, syncN = 1'b1, clkPinIn = 1'b0;
   logic        dataReady = 1'b0, fifoIrq = 1'b0, fifoReady = 1'b0;
   logic [7:0]  adr = 8'h00, rd;
   logic [31:0] datW = 32'h0, datR, q;
   logic        ack, irq, sclk, csN, din, dout, doutOeN, intPin, clkPinOut, clkPinOeN, syncAlign, fifoClear;
   logic        seqRestart, mclkTick;
   int          nErrors = 0, checks = 0;

   adp_pin_if dut (.sys_clk(sys_clk), .nrst(nrst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(datW), .dat_o(datR), .ack_o(ack), .irq(irq), .sclk(sclk), .csN(csN), .din(din), .dout(dout),
      .doutOeN(doutOeN), .intPin(intPin), .syncN(syncN), .clkPinIn(clkPinIn), .clkPinOut(clkPinOut),
      .clkPinOeN(clkPinOeN), .dataReady(dataReady), .fifoIrq(fifoIrq), .fifoReady(fifoReady),
      .syncAlign(syncAlign), .fifoClear(fifoClear), .seqRestart(seqRestart), .mclkTick(mclkTick));
   adp_spi_host host (.sys_clk(sys_clk), .dout(dout), .sclk(sclk), .csN(csN), .din(din));

   // 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // verdict, the one place the run ends
   task automatic report_and_stop();
      $display("errors %0d checks %0d", nErrors, checks);
      if (nErrors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // exact four-state compare
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         nErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // classic cycle; read data taken into q at the ack edge, bounded wait
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      datW <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = datR;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         nErrors++;
         report_and_stop();
      end
   endtask

   // gated serial write, read back, out-of-range select, three-wire frames
   task automatic t_serial();
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, q);
      wb(1'b1, ADR_MASK, 32'h1);
      host.xfer(16'h03A5, 1'b1, 1'b0, rd);
      chk("irq", 32'h1, irq);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("status", 32'h1, q);
      tick(2);
      chk("irq", 32'h0, irq);
      host.xfer(16'h4300, 1'b0, 1'b0, rd);
      chk("read", 32'hA5, rd);
      chk("oe", 32'h1, doutOeN);
      host.xfer(16'h145A, 1'b0, 1'b1, rd);
      host.xfer(16'h5400, 1'b0, 1'b1, rd);
      chk("sel 20", 32'h0, rd);
      host.xfer(16'h053C, 1'b0, 1'b1, rd);
      host.xfer(16'h4500, 1'b0, 1'b0, rd);
      chk("3-wire", 32'h3C, rd);
   endtask

   // pin source choice; data-ready event masked then unmasked
   task automatic t_int();
      wb(1'b1, ADR_MASK, 32'h0);
      wb(1'b0, ADR_STATUS, 32'h0);
      dataReady <= 1'b1;
      tick(3);
      chk("int", 32'h1, intPin);
      chk("irq", 32'h0, irq);
      wb(1'b1, ADR_CTRL, 32'h3);
      fifoReady <= 1'b1;
      tick(2);
      chk("int", 32'h0, intPin);
      chk("fifo ready", 32'h0, dout);
      fifoIrq <= 1'b1;
      tick(2);
      chk("int", 32'h1, intPin);
      wb(1'b1, ADR_MASK, 32'h8);
      tick(2);
      chk("irq", 32'h1, irq);
      wb(1'b0, ADR_STATUS, 32'h0);
      chk("status", 32'h8, q);
      fifoIrq <= 1'b0;
      dataReady <= 1'b0;
   endtask

   // sync pulse; fifo clear only when enabled
   task automatic t_sync(input logic clr);
      logic [31:0] nA = 32'h0, nC = 32'h0, nR = 32'h0;
      wb(1'b1, ADR_CTRL, {26'h0, clr, 5'h0});
      syncN <= 1'b0;
      repeat (12) begin
         @(posedge sys_clk);
         nA += {31'h0, syncAlign};
         nC += {31'h0, fifoClear};
         nR += {31'h0, seqRestart};
      end
      syncN <= 1'b1;
      chk("align", 32'h1, nA);
      chk("clear", {31'h0, clr}, nC);
      chk("restart", {31'h0, clr}, nR);
   endtask

   // clock pin: driven out, released for input, then carrying data ready
   task automatic t_clk();
      logic [31:0] nE = 32'h0, nT = 32'h0;
      logic        prev;
      wb(1'b1, ADR_CTRL, 32'h4);
      tick(3);
      prev = clkPinOut;
      repeat (40) begin
         @(posedge sys_clk);
         nE += {31'h0, clkPinOut & ~prev};
         nT += {31'h0, mclkTick};
         prev = clkPinOut;
      end
      chk("edges", 32'(40 / (2 * MCLK_HALF_CYC)), nE);
      chk("ticks", 32'(40 / (2 * MCLK_HALF_CYC)), nT);
      chk("oe", 32'h0, clkPinOeN);
      wb(1'b1, ADR_CTRL, 32'h8);
      tick(2);
      chk("oe", 32'h1, clkPinOeN);
      // four rising edges of an external clock on the pin, one tick each
      nT = 32'h0;
      for (int k = 0; k < 48; k++) begin
         @(posedge sys_clk);
         nT += {31'h0, mclkTick};
         if (k % 6 == 0) clkPinIn <= ~clkPinIn;
      end
      chk("ext ticks", 32'h4, nT);
      wb(1'b1, ADR_CTRL, 32'h10);
      dataReady <= 1'b1;
      tick(3);
      chk("pin", 32'h1, clkPinOut);
   endtask

   // reset for four cycles, then the scenarios
   initial begin
      tick(4);
      nrst <= 1'b1;
      tick(4);
      t_serial();
      t_int();
      t_sync(1'b0);
      t_sync(1'b1);
      t_clk();
      report_and_stop();
   end
endmodule
